//--- verilog/etcc_timer.sv
`timescale 1ns/1ps
module etcc_timer (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [5:0] address_in,
    input wire logic read_in,
    input wire logic write_in,
    input wire logic [31:0] writedata_in,
    output logic [31:0] readdata_out,
    output logic waitrequest_out,
    input wire logic event_capture_input_in,
    output logic timer_out_a_out,
    output logic timer_out_b_out,
    output logic match_a_irq_out,
    output logic match_b_irq_out,
    output logic edge_irq_out
);
    etcc_pkg::etcc_cfg_t cfg;
    etcc_pkg::etcc_chan_t chan [2];
    etcc_pkg::etcc_mode_t mode [2];
    logic [15:0] compare_a;
    logic [15:0] compare_b;
    logic [15:0] capture_value;
    logic [15:0] main_up_counter;
    logic [15:0] next_count;
    logic [3:0] status;
    logic [1:0] trigger;
    logic [1:0] hit;
    logic [1:0] active;
    logic [1:0] next_pin;
    logic start_pending;
    logic overflow_pulse;
    logic clear_pulse;
    logic pre_tick;
    logic edge_pulse;
    logic count_tick;
    logic counting;
    logic clr_hit;
    logic bus_req;
    logic wr_acc;
    logic [31:0] next_readdata;

    default clocking @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    etcc_prescaler u_prescaler (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .select_in(cfg.prescale),
        .tick_out(pre_tick)
    );

    etcc_edge_sync u_edge (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .pin_in(event_capture_input_in),
        .edge_mode_in(cfg.edge_mode),
        .edge_out(edge_pulse)
    );

    // bus side: one wait cycle, then the accepting edge
    assign bus_req = read_in || write_in;
    assign wr_acc = write_in && !waitrequest_out;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            waitrequest_out <= 1'b1;
        end else begin
            waitrequest_out <= !(bus_req && waitrequest_out);
        end
    end

    always_comb begin
        next_readdata = '0;
        case (address_in)
            etcc_pkg::OFS_TIMER_CTRL: next_readdata[0] = cfg.count_run_bit;
            etcc_pkg::OFS_PRESCALE: next_readdata[3:0] = cfg.prescale;
            etcc_pkg::OFS_CAPMODE: begin
                next_readdata[0] = cfg.out_mode_low;
                next_readdata[1] = cfg.out_mode_high;
                next_readdata[2] = cfg.clear_on_match_b;
            end
            etcc_pkg::OFS_OUTPUT_CTRL: begin
                next_readdata[0] = chan[0].out_enable;
                next_readdata[1] = chan[0].level_select;
                next_readdata[2] = chan[1].out_enable;
                next_readdata[3] = chan[1].level_select;
            end
            etcc_pkg::OFS_ONESHOT: begin
                next_readdata[0] = chan[0].oneshot_select;
                next_readdata[1] = chan[1].oneshot_select;
            end
            etcc_pkg::OFS_EDGE_MODE: next_readdata[1:0] = cfg.edge_mode;
            etcc_pkg::OFS_COMPARE_A: next_readdata[15:0] = compare_a;
            etcc_pkg::OFS_COMPARE_B: next_readdata[15:0] = compare_b;
            etcc_pkg::OFS_CAPTURE: next_readdata[15:0] = capture_value;
            etcc_pkg::OFS_COUNTER: next_readdata[15:0] = main_up_counter;
            etcc_pkg::OFS_STATUS: next_readdata[3:0] = status;
            default: next_readdata = '0;
        endcase
    end

    // data sampled in the wait cycle, held through the accepting edge
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            readdata_out <= '0;
        end else if (read_in && waitrequest_out) begin
            readdata_out <= next_readdata;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cfg <= '{prescale: etcc_pkg::PRESCALE_RESET, default: '0};
            chan[0] <= '0;
            chan[1] <= '0;
            compare_a <= '0;
            compare_b <= '0;
        end else if (wr_acc) begin
            case (address_in)
                etcc_pkg::OFS_TIMER_CTRL: cfg.count_run_bit <= writedata_in[0];
                etcc_pkg::OFS_PRESCALE: cfg.prescale <= writedata_in[3:0];
                etcc_pkg::OFS_CAPMODE: begin
                    cfg.out_mode_low <= writedata_in[0];
                    cfg.out_mode_high <= writedata_in[1];
                    cfg.clear_on_match_b <= writedata_in[2];
                end
                etcc_pkg::OFS_OUTPUT_CTRL: begin
                    chan[0].out_enable <= writedata_in[0];
                    chan[0].level_select <= writedata_in[1];
                    chan[1].out_enable <= writedata_in[2];
                    chan[1].level_select <= writedata_in[3];
                end
                etcc_pkg::OFS_ONESHOT: begin
                    chan[0].oneshot_select <= writedata_in[0];
                    chan[1].oneshot_select <= writedata_in[1];
                end
                etcc_pkg::OFS_EDGE_MODE: cfg.edge_mode <= writedata_in[1:0];
                etcc_pkg::OFS_COMPARE_A: compare_a <= writedata_in[15:0];
                etcc_pkg::OFS_COMPARE_B: compare_b <= writedata_in[15:0];
                default: cfg <= cfg;
            endcase
        end
    end

    // one-shot start bits are write-only strobes
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            trigger <= '0;
        end else if (wr_acc && address_in == etcc_pkg::OFS_ONESHOT) begin
            trigger <= writedata_in[3:2];
        end else begin
            trigger <= '0;
        end
    end

    // the external edge is the count clock with no other setting
    assign count_tick = (cfg.prescale == etcc_pkg::PRESCALE_EXT) ? edge_pulse : pre_tick;
    assign counting = cfg.count_run_bit && count_tick && !start_pending;
    assign clr_hit = cfg.clear_on_match_b && main_up_counter == compare_b;

    always_comb begin
        if (start_pending || clr_hit) begin
            next_count = etcc_pkg::COUNT_ZERO;
        end else begin
            next_count = main_up_counter + etcc_pkg::COUNT_STEP;
        end
    end

    // a restart waits for the first count clock, which loads zero
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            start_pending <= 1'b0;
        end else if (wr_acc && address_in == etcc_pkg::OFS_TIMER_CTRL &&
                     writedata_in[0] && !cfg.count_run_bit) begin
            start_pending <= 1'b1;
        end else if (!cfg.count_run_bit || count_tick) begin
            start_pending <= 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            main_up_counter <= etcc_pkg::COUNT_ZERO;
        end else if (!cfg.count_run_bit) begin
            main_up_counter <= etcc_pkg::COUNT_ZERO;
        end else if (count_tick) begin
            main_up_counter <= next_count;
        end
    end

    // event pulses toward the output logic and the interrupt lines
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            hit <= '0;
            overflow_pulse <= 1'b0;
            clear_pulse <= 1'b0;
        end else begin
            hit[0] <= counting && next_count == compare_a;
            hit[1] <= counting && next_count == compare_b;
            overflow_pulse <= counting && !clr_hit &&
                main_up_counter == etcc_pkg::COUNT_FULL;
            clear_pulse <= counting && clr_hit;
        end
    end

    assign match_a_irq_out = hit[0];
    assign match_b_irq_out = hit[1];

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            edge_irq_out <= 1'b0;
            capture_value <= etcc_pkg::COUNT_ZERO;
        end else begin
            edge_irq_out <= edge_pulse;
            if (edge_pulse && cfg.count_run_bit) begin
                capture_value <= main_up_counter;
            end
        end
    end

    // sticky flags, write one to clear; a new event beats the clear
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            status <= '0;
        end else begin
            status <= (status & ~((wr_acc && address_in == etcc_pkg::OFS_STATUS) ?
                writedata_in[3:0] : 4'h0)) | {overflow_pulse, edge_pulse, hit};
        end
    end

    function automatic etcc_pkg::etcc_mode_t decode_mode(
        input logic is_b,
        input logic oneshot,
        input logic [1:0] md,
        input logic clr
    );
        if (oneshot) begin
            return etcc_pkg::ETCC_ONESHOT;
        end
        if (!is_b && md == 2'b11 && clr) begin
            return etcc_pkg::ETCC_PPG;
        end
        if (!is_b && (md == 2'b01 || md == 2'b10) && !clr) begin
            return etcc_pkg::ETCC_PWM;
        end
        if (is_b && md == 2'b10 && !clr) begin
            return etcc_pkg::ETCC_PWM;
        end
        // unlisted combinations fall back to toggle
        return etcc_pkg::ETCC_TOGGLE;
    endfunction : decode_mode

    assign mode[0] = decode_mode(1'b0, chan[0].oneshot_select,
        {cfg.out_mode_high, cfg.out_mode_low}, cfg.clear_on_match_b);
    assign mode[1] = decode_mode(1'b1, chan[1].oneshot_select,
        {cfg.out_mode_high, cfg.out_mode_low}, cfg.clear_on_match_b);

    // per channel active state; pwm idles active when stopped
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            active <= '0;
        end else begin
            for (int ch = 0; ch < 2; ch++) begin
                case (mode[ch])
                    etcc_pkg::ETCC_TOGGLE: begin
                        if (!cfg.count_run_bit) begin
                            active[ch] <= 1'b0;
                        end else if (hit[ch]) begin
                            active[ch] <= !active[ch];
                        end
                    end
                    etcc_pkg::ETCC_PWM: begin
                        if (!cfg.count_run_bit || overflow_pulse) begin
                            active[ch] <= 1'b1;
                        end else if (hit[ch]) begin
                            active[ch] <= 1'b0;
                        end
                    end
                    etcc_pkg::ETCC_PPG: begin
                        if (!cfg.count_run_bit || clear_pulse) begin
                            active[ch] <= 1'b1;
                        end else if (hit[ch]) begin
                            active[ch] <= 1'b0;
                        end
                    end
                    etcc_pkg::ETCC_ONESHOT: begin
                        if (trigger[ch]) begin
                            active[ch] <= 1'b1;
                        end else if (hit[ch] || !cfg.count_run_bit) begin
                            active[ch] <= 1'b0;
                        end
                    end
                    default: active[ch] <= 1'b0;
                endcase
            end
        end
    end

    always_comb begin
        for (int ch = 0; ch < 2; ch++) begin
            if (!chan[ch].out_enable) begin
                next_pin[ch] = !chan[ch].level_select;
            end else if (mode[ch] == etcc_pkg::ETCC_PWM || mode[ch] == etcc_pkg::ETCC_PPG) begin
                next_pin[ch] = active[ch] ^ chan[ch].level_select;
            end else begin
                next_pin[ch] = !active[ch] ^ chan[ch].level_select;
            end
        end
    end

    // pins idle high out of reset, matching a disabled output
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            timer_out_a_out <= 1'b1;
            timer_out_b_out <= 1'b1;
        end else begin
            timer_out_a_out <= next_pin[0];
            timer_out_b_out <= next_pin[1];
        end
    end

    chk_stop_clears: assert property (
        $fell(cfg.count_run_bit) |=> main_up_counter == etcc_pkg::COUNT_ZERO)
        else $error("counter not zero after stop");

    chk_first_tick_zero: assert property (
        cfg.count_run_bit && start_pending && count_tick
        |=> main_up_counter == etcc_pkg::COUNT_ZERO && !start_pending)
        else $error("first count clock did not load zero");

    chk_rerun_keeps: assert property (
        wr_acc && address_in == etcc_pkg::OFS_TIMER_CTRL && writedata_in[0] &&
        cfg.count_run_bit && !count_tick
        |=> $stable(main_up_counter) && $stable(start_pending))
        else $error("second run write disturbed count");

    chk_event_count: assert property (
        cfg.prescale == etcc_pkg::PRESCALE_EXT && edge_pulse && cfg.count_run_bit &&
        !start_pending && !clr_hit
        |=> main_up_counter == 16'($past(main_up_counter) + etcc_pkg::COUNT_STEP))
        else $error("external edge not counted");

    chk_match_pulse: assert property (
        counting && next_count == compare_a
        |=> match_a_irq_out ##1 !match_a_irq_out || counting)
        else $error("match a pulse missing");

    chk_match_clear: assert property (
        cfg.count_run_bit && !start_pending && clr_hit && !count_tick
        ##1 cfg.count_run_bit && count_tick
        |=> main_up_counter == etcc_pkg::COUNT_ZERO)
        else $error("match clear not on next count clock");

    chk_capture_take: assert property (
        edge_pulse && cfg.count_run_bit |=> capture_value == $past(main_up_counter))
        else $error("capture missed counter value");

    chk_capture_hold: assert property (
        !edge_pulse |=> $stable(capture_value))
        else $error("capture changed without edge");

    chk_fixed_level: assert property (
        !chan[0].out_enable |=> timer_out_a_out == !$past(chan[0].level_select))
        else $error("disabled output a not at fixed level");
endmodule : etcc_timer

//--- verilog/etcc_pkg.sv
package etcc_pkg;
    localparam logic [5:0] OFS_TIMER_CTRL = 6'h00;
    localparam logic [5:0] OFS_PRESCALE = 6'h04;
    localparam logic [5:0] OFS_CAPMODE = 6'h08;
    localparam logic [5:0] OFS_OUTPUT_CTRL = 6'h0c;
    localparam logic [5:0] OFS_ONESHOT = 6'h10;
    localparam logic [5:0] OFS_EDGE_MODE = 6'h14;
    localparam logic [5:0] OFS_COMPARE_A = 6'h18;
    localparam logic [5:0] OFS_COMPARE_B = 6'h1c;
    localparam logic [5:0] OFS_CAPTURE = 6'h20;
    localparam logic [5:0] OFS_COUNTER = 6'h24;
    localparam logic [5:0] OFS_STATUS = 6'h28;
    localparam logic [3:0] PRESCALE_RESET = 4'h1;
    localparam logic [3:0] PRESCALE_MIN = 4'h1;
    localparam logic [3:0] PRESCALE_MAX = 4'h9;
    localparam logic [3:0] PRESCALE_EXT = 4'hf;
    localparam logic [9:0] PRESCALE_BASE = 10'h004;
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h2;
    localparam logic [15:0] COUNT_ZERO = 16'h0000;
    localparam logic [15:0] COUNT_FULL = 16'hffff;
    localparam logic [15:0] COUNT_STEP = 16'h0001;

    typedef enum logic [1:0] {
        ETCC_TOGGLE = 2'b00,
        ETCC_PWM = 2'b01,
        ETCC_PPG = 2'b10,
        ETCC_ONESHOT = 2'b11
    } etcc_mode_t;

    typedef struct packed {
        logic out_enable;
        logic level_select;
        logic oneshot_select;
    } etcc_chan_t;

    typedef struct packed {
        logic count_run_bit;
        logic clear_on_match_b;
        logic out_mode_high;
        logic out_mode_low;
        logic [3:0] prescale;
        logic [1:0] edge_mode;
    } etcc_cfg_t;
endpackage : etcc_pkg

//--- verilog/etcc_prescaler.sv
`timescale 1ns/1ps
module etcc_prescaler (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [3:0] select_in,
    output logic tick_out
);
    logic [9:0] div_count;
    logic [9:0] div_last;
    logic sel_ok;

    assign sel_ok = (select_in >= etcc_pkg::PRESCALE_MIN) &&
        (select_in <= etcc_pkg::PRESCALE_MAX);
    // divide by four, doubling with each select step
    assign div_last = 10'((etcc_pkg::PRESCALE_BASE <<
        (select_in - etcc_pkg::PRESCALE_MIN)) - 10'h001);

    // free running, so a restart lands on the next natural tick
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div_count <= '0;
            tick_out <= 1'b0;
        end else if (!sel_ok || div_count >= div_last) begin
            div_count <= '0;
            tick_out <= sel_ok;
        end else begin
            div_count <= div_count + 10'h001;
            tick_out <= 1'b0;
        end
    end
endmodule : etcc_prescaler

//--- verilog/etcc_edge_sync.sv
`timescale 1ns/1ps
module etcc_edge_sync (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic pin_in,
    input wire logic [1:0] edge_mode_in,
    output logic edge_out
);
    logic sync_first;
    logic sync_second;
    logic sync_prev;
    logic rise;
    logic fall;

    assign rise = sync_second && !sync_prev;
    assign fall = !sync_second && sync_prev;

    // two stages against metastability, a third for the edge compare
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync_first <= 1'b0;
            sync_second <= 1'b0;
            sync_prev <= 1'b0;
        end else begin
            sync_first <= pin_in;
            sync_second <= sync_first;
            sync_prev <= sync_second;
        end
    end

    // three-clock phases give one pulse per edge at fclk/6
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            edge_out <= 1'b0;
        end else begin
            case (edge_mode_in)
                etcc_pkg::EDGE_RISE: edge_out <= rise;
                etcc_pkg::EDGE_FALL: edge_out <= fall;
                etcc_pkg::EDGE_BOTH: edge_out <= rise || fall;
                default: edge_out <= 1'b0;
            endcase
        end
    end
endmodule : etcc_edge_sync

//--- verif/etcc_pulse_source.sv
`timescale 1ns/1ps
module etcc_pulse_source (
    input wire logic clk_in,
    input wire logic load_a_in,
    input wire logic load_b_in,
    output logic pin_out
);
    initial begin
        pin_out = 1'b0;
    end

    // three clocks a phase: the fastest pulse train the counter must keep up with
    task automatic send(input int pulses);
        repeat (pulses) begin
            @(posedge clk_in);
            pin_out <= 1'b1;
            repeat (3) @(posedge clk_in);
            pin_out <= 1'b0;
            repeat (2) @(posedge clk_in);
        end
    endtask : send
endmodule : etcc_pulse_source

//--- verif/event_timer_compare_capture_test.sv
`timescale 1ns/1ps
module event_timer_compare_capture_test;
    logic clk_in, rst_n_in, read, write, waitrequest, pin, ta, tb, ma, mb, ei;
    logic [5:0] address;
    logic [31:0] writedata, readdata, d, c0;
    logic pa, pb;
    int failures = 0;
    int tests_run = 0;
    int cycles = 0;
    int n, k;
    int edges = 0;

    etcc_timer dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .address_in(address),
        .read_in(read), .write_in(write), .writedata_in(writedata),
        .readdata_out(readdata), .waitrequest_out(waitrequest),
        .event_capture_input_in(pin), .timer_out_a_out(ta), .timer_out_b_out(tb),
        .match_a_irq_out(ma), .match_b_irq_out(mb), .edge_irq_out(ei));
    etcc_pulse_source src_u (.clk_in(clk_in), .load_a_in(ta), .load_b_in(tb),
        .pin_out(pin));

    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : complete_run

    // a hang costs a mismatch and ends the whole run at cycle 20000
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            complete_run();
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // edge interrupt pulses seen since reset
    always @(posedge clk_in) begin
        if (ei === 1'b1) edges <= edges + 1;
    end

    // stops on the edge at which the match b pulse is sampled high
    task automatic wait_b();
        n = 0;
        while (mb !== 1'b1 && n < 200) begin
            @(posedge clk_in);
            n++;
        end
    endtask : wait_b

    task automatic wr(input logic [5:0] a, input logic [31:0] v);
        address <= a;
        writedata <= v;
        write <= 1'b1;
        do @(posedge clk_in); while (waitrequest !== 1'b0);
        write <= 1'b0;
        @(posedge clk_in);
    endtask : wr

    task automatic rd(input logic [5:0] a, output logic [31:0] v);
        address <= a;
        read <= 1'b1;
        do @(posedge clk_in); while (waitrequest !== 1'b0);
        v = readdata;
        read <= 1'b0;
        @(posedge clk_in);
    endtask : rd

    initial begin
        rst_n_in = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = 6'h00;
        writedata = 32'h00000000;
        repeat (6) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        check("pin a at reset", 32'h1, {31'h0, ta});
        check("pin b at reset", 32'h1, {31'h0, tb});
        rd(6'h3c, d);
        check("unmapped read", 32'h0, d);
        $display("test reset done");

        wr(etcc_pkg::OFS_PRESCALE, 32'h0000000f);
        for (int m = 0; m < 3; m++) begin
            wr(etcc_pkg::OFS_EDGE_MODE, 32'(m));
            wr(etcc_pkg::OFS_TIMER_CTRL, 32'h1);
            src_u.send(2);
            wr(etcc_pkg::OFS_TIMER_CTRL, 32'h1);
            src_u.send(2);
            repeat (8) @(posedge clk_in);
            rd(etcc_pkg::OFS_COUNTER, d);
            check("event count", (m == 2) ? 32'h7 : 32'h3, d);
            wr(etcc_pkg::OFS_TIMER_CTRL, 32'h0);
            rd(etcc_pkg::OFS_COUNTER, d);
            check("count after stop", 32'h0, d);
        end
        check("edge pulses", 32'h10, 32'(edges));
        $display("test event count done");

        wr(etcc_pkg::OFS_EDGE_MODE, 32'h3);
        wr(etcc_pkg::OFS_TIMER_CTRL, 32'h1);
        wr(etcc_pkg::OFS_STATUS, 32'hf);
        rd(etcc_pkg::OFS_CAPTURE, c0);
        src_u.send(2);
        repeat (8) @(posedge clk_in);
        rd(etcc_pkg::OFS_CAPTURE, d);
        check("capture hold", c0, d);
        rd(etcc_pkg::OFS_COUNTER, d);
        check("no edge no count", 32'h0, d);
        rd(etcc_pkg::OFS_STATUS, d);
        check("no edge flag", 32'h0, d);
        wr(etcc_pkg::OFS_EDGE_MODE, 32'h1);
        src_u.send(1);
        repeat (8) @(posedge clk_in);
        rd(etcc_pkg::OFS_COUNTER, d);
        check("one edge count", 32'h0, d);
        rd(etcc_pkg::OFS_STATUS, d);
        check("one edge flag", 32'h4, d);
        src_u.send(2);
        repeat (8) @(posedge clk_in);
        rd(etcc_pkg::OFS_CAPTURE, d);
        check("capture taken", 32'h1, d);
        wr(etcc_pkg::OFS_TIMER_CTRL, 32'h0);
        $display("test capture done");

        wr(etcc_pkg::OFS_PRESCALE, 32'h1);
        wr(etcc_pkg::OFS_CAPMODE, 32'h4);
        wr(etcc_pkg::OFS_COMPARE_A, 32'h3);
        wr(etcc_pkg::OFS_COMPARE_B, 32'h5);
        wr(etcc_pkg::OFS_OUTPUT_CTRL, 32'h5);
        wr(etcc_pkg::OFS_TIMER_CTRL, 32'h1);
        n = 0;
        while (mb !== 1'b1 && n < 200) begin
            @(posedge clk_in);
            n++;
        end
        pa = ta;
        pb = tb;
        n = 0;
        k = 0;
        do begin
            @(posedge clk_in);
            n++;
            if (ma === 1'b1) k++;
        end while (mb !== 1'b1 && n < 200);
        check("match b period", 32'd24, 32'(n));
        check("match a pulses", 32'h1, 32'(k));
        check("pin a toggled", {31'h0, ~pa}, {31'h0, ta});
        check("pin b toggled", {31'h0, ~pb}, {31'h0, tb});
        $display("test compare done");

        wr(etcc_pkg::OFS_CAPMODE, 32'h7);
        wait_b();
        k = 0;
        repeat (24) begin
            @(posedge clk_in);
            if (ta === 1'b1) k++;
        end
        check("ppg high cycles", 32'hc, 32'(k));
        wait_b();
        wr(etcc_pkg::OFS_ONESHOT, 32'ha);
        repeat (2) @(posedge clk_in);
        check("one-shot b active", 32'h0, {31'h0, tb});
        wait_b();
        repeat (2) @(posedge clk_in);
        check("one-shot b ended", 32'h1, {31'h0, tb});
        $display("test output modes done");

        wr(etcc_pkg::OFS_TIMER_CTRL, 32'h0);
        wr(etcc_pkg::OFS_OUTPUT_CTRL, 32'ha);
        repeat (4) @(posedge clk_in);
        check("pins fixed low", 32'h0, {30'h0, ta, tb});
        wr(etcc_pkg::OFS_OUTPUT_CTRL, 32'h0);
        repeat (4) @(posedge clk_in);
        check("pins fixed high", 32'h3, {30'h0, ta, tb});
        $display("test fixed level done");
        complete_run();
    end
endmodule : event_timer_compare_capture_test
